// file: shared/can_tx_loader_pkg.sv
// Purpose: constants, layouts and helpers for the transmit object loader
// Assumes: one transmit FIFO and one transmit queue share the message RAM
// Notes: byte addresses on the register port
//
// Notes on behaviour
// - next object address is base 0x400 plus the user address.
// - head increment advances head one object and updates user address.
// - queue uses its own user address and increment bit, like a FIFO.
// - T0 holds base identifier 10:0 and extended identifier 28:11.
// - in FD frames T0 bit 29 is a twelfth base identifier bit.
// - T0 bits 31:30 are unimplemented and ignored.
// - T1 bits 31:9 hold a 23-bit sequence tag, not transmitted.
// - reduced variant keeps only the low seven sequence tag bits.
// - gateway mode sends ESI as object ESI OR own error passive.
// - normally ESI is 1 when error passive, 0 when error active.
// - T1 bit 7 selects FD format, bit 6 selects bit rate switch.
// - T1 bit 5 requests a remote frame, classic frames only.
// - T1 bit 4 selects base or extended identifier.
// - T1 bits 3:0 hold the DLC giving the payload byte count.
// - a three-bit payload size field per FIFO sets object capacity.
// - classic-only mode ignores FDF and sends classic frames.
// - BRS set uses the data bit rate in the data phase.
package can_tx_loader_pkg;
  localparam logic [11:0] RAM_BASE = 12'h400;
  localparam int RAM_WORDS = 256;
  localparam int OBJ_DEPTH = 4;
  localparam int HDR_WORDS = 2;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] FIFO_CTRL_OFS = 12'h004;
  localparam logic [11:0] FIFO_STAT_OFS = 12'h008;
  localparam logic [11:0] FIFO_UA_OFS = 12'h00c;
  localparam logic [11:0] QUEUE_CTRL_OFS = 12'h010;
  localparam logic [11:0] QUEUE_STAT_OFS = 12'h014;
  localparam logic [11:0] QUEUE_UA_OFS = 12'h018;
  localparam int GATEWAY_BIT = 0;
  localparam int CLASSIC_BIT = 1;
  localparam int REDUCED_SEQ_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int INC_BIT = 8;
  localparam logic [2:0] PAYLOAD_SIZE_FIELD_RESET = 3'h0;
  localparam int NOT_FULL_BIT = 0;
  localparam int EMPTY_BIT = 1;
  localparam int REFUSED_BIT = 2;
  localparam int COUNT_LSB = 8;
  localparam int T0_SID_LSB = 0;
  localparam int T0_EID_LSB = 11;
  localparam int T0_BASE_IDENTIFIER_BIT_ELEVEN_BIT = 29;
  localparam int T1_SEQ_LSB = 9;
  localparam int T1_ESI_BIT = 8;
  localparam int T1_FDF_BIT = 7;
  localparam int T1_BRS_BIT = 6;
  localparam int T1_RTR_BIT = 5;
  localparam int T1_IDE_BIT = 4;
  localparam int T1_DLC_LSB = 0;
  localparam int SEQ_REDUCED_BITS = 7;

  function automatic logic [6:0] plsizeBytes(input logic [2:0] code);
    case (code)
      3'h0: plsizeBytes = 7'h08;
      3'h1: plsizeBytes = 7'h0c;
      3'h2: plsizeBytes = 7'h10;
      3'h3: plsizeBytes = 7'h14;
      3'h4: plsizeBytes = 7'h18;
      3'h5: plsizeBytes = 7'h20;
      3'h6: plsizeBytes = 7'h30;
      default: plsizeBytes = 7'h40;
    endcase
  endfunction

  function automatic logic [6:0] dlcBytes(input logic [3:0] dlc, input logic fd);
    if (dlc <= 4'h8 || !fd)
      dlcBytes = (dlc > 4'h8) ? 7'h08 : {3'h0, dlc};
    else
      case (dlc)
        4'h9: dlcBytes = 7'h0c;
        4'ha: dlcBytes = 7'h10;
        4'hb: dlcBytes = 7'h14;
        4'hc: dlcBytes = 7'h18;
        4'hd: dlcBytes = 7'h20;
        4'he: dlcBytes = 7'h30;
        default: dlcBytes = 7'h40;
      endcase
  endfunction
endpackage

// file: shared/tx_object_if.sv
`timescale 1ns/100ps
// Purpose: carries a raw header and its decoded fields between loader and decoder
// Assumes: single clock, purely combinational path
// Notes: none
interface tx_object_if;
  logic [31:0] t0;
  logic [31:0] t1;
  logic gatewayMode;
  logic classicOnly;
  logic reducedSeq;
  logic errPassive;
  logic [6:0] capBytes;
  logic [11:0] baseId;
  logic [17:0] extId;
  logic [22:0] seqTag;
  logic esi;
  logic fdFrame;
  logic brs;
  logic rtr;
  logic ide;
  logic [3:0] dlc;
  logic [6:0] byteCount;
  modport loader (output t0, t1, gatewayMode, classicOnly, reducedSeq, errPassive, capBytes,
    input baseId, extId, seqTag, esi, fdFrame, brs, rtr, ide, dlc, byteCount);
  modport decoder (input t0, t1, gatewayMode, classicOnly, reducedSeq, errPassive, capBytes,
    output baseId, extId, seqTag, esi, fdFrame, brs, rtr, ide, dlc, byteCount);
endinterface

// file: verilog/tx_object_decoder.sv
`timescale 1ns/100ps
// Purpose: splits header words T0 and T1 into transmit frame fields
// Assumes: mode bits come from the loader control register
// Notes: combinational; the loader registers the results
module tx_object_decoder
  import can_tx_loader_pkg::*;
(
  tx_object_if.decoder obj
);
  logic fd;
  logic [6:0] wanted;

  // ------------------------------------------------------------
  // format
  // ------------------------------------------------------------
  assign fd = obj.t1[T1_FDF_BIT] & ~obj.classicOnly;
  assign obj.fdFrame = fd;
  assign obj.brs = fd & obj.t1[T1_BRS_BIT];
  assign obj.rtr = ~fd & obj.t1[T1_RTR_BIT];
  assign obj.ide = obj.t1[T1_IDE_BIT];
  assign obj.dlc = obj.t1[T1_DLC_LSB +: 4];

  // ------------------------------------------------------------
  // identifiers; bits 31:30 of T0 never looked at
  // ------------------------------------------------------------
  assign obj.baseId = {fd & obj.t0[T0_BASE_IDENTIFIER_BIT_ELEVEN_BIT], obj.t0[T0_SID_LSB +: 11]};
  assign obj.extId = obj.t0[T0_EID_LSB +: 18];

  // ------------------------------------------------------------
  // sequence tag and error state
  // ------------------------------------------------------------
  assign obj.seqTag = obj.reducedSeq
    ? {16'h0000, obj.t1[T1_SEQ_LSB +: SEQ_REDUCED_BITS]}
    : obj.t1[T1_SEQ_LSB +: 23];
  assign obj.esi = obj.gatewayMode
    ? (obj.t1[T1_ESI_BIT] | obj.errPassive)
    : obj.errPassive;

  // ------------------------------------------------------------
  // payload length, never beyond the object's capacity
  // ------------------------------------------------------------
  assign wanted = dlcBytes(obj.dlc, fd);
  assign obj.byteCount = (wanted > obj.capBytes) ? obj.capBytes : wanted;
endmodule // tx_object_decoder

// file: verilog/can_tx_loader.sv
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
// Purpose: message RAM with one transmit FIFO and one transmit queue
// Assumes: host on the register port, protocol engine on the eng ports
// Notes: source 0 is the FIFO, source 1 the queue; objects packed back to back
module can_tx_loader
  import can_tx_loader_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  input wire logic errPassive,
  input wire logic engSel,
  input wire logic engTake,
  input wire logic [3:0] engWordIdx,
  output logic engValid,
  output logic [31:0] engWord,
  output logic [11:0] frameBaseId,
  output logic [17:0] frameExtId,
  output logic [22:0] frameSeqTag,
  output logic frameEsi,
  output logic frameFd,
  output logic frameBrs,
  output logic frameRtr,
  output logic frameIde,
  output logic [3:0] frameDlc,
  output logic [6:0] frameByteCount,
  output logic fifoNotFull,
  output logic queueNotFull
);
  import can_tx_loader_pkg::*;

  // ------------------------------------------------------------
  // storage and state
  // ------------------------------------------------------------
  logic [31:0] msgRam [RAM_WORDS];
  logic [2:0] ctrl_reg;
  logic [2:0] payload_size_field_reg [2];
  logic [2:0] head_reg [2];
  logic [2:0] tail_reg [2];
  logic refused_reg [2];
  logic [4:0] objWords [2];
  logic [6:0] regionBase [2];
  logic [7:0] headWord [2];
  logic [7:0] tailWord [2];
  logic [2:0] count [2];
  logic full [2];
  logic empty [2];
  logic [11:0] userAddr [2];
  logic [31:0] statusWord [2];
  logic ramHit;
  logic [7:0] ramIdx;
  logic [7:0] selTail;
  logic [7:0] payloadIdx;
  logic [31:0] rdValue;

  tx_object_if obj ();

  tx_object_decoder decoder (
    .obj(obj)
  );

  // ------------------------------------------------------------
  // ram window decode
  // ------------------------------------------------------------
  // 0x400..0x7ff; ram fits in one aligned kilobyte so two bits decide
  assign ramHit = (regAddr[11:10] == RAM_BASE[11:10]);
  assign ramIdx = regAddr[9:2];

  always_ff @(posedge clk_sys)
  begin
    if (regWrEn && ramHit)
    begin
      // little-endian payload bytes land as the host packs them
      msgRam[ramIdx] <= regWrData;
    end
  end

  // ------------------------------------------------------------
  // global control
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RESET;
    end
    else if (regWrEn && regAddr == CTRL_OFS)
    begin
      ctrl_reg <= regWrData[2:0];
    end
  end

  // ------------------------------------------------------------
  // per source: pointers, payload size, user address
  // ------------------------------------------------------------
  generate
    for (genvar s = 0; s < 2; s++)
    begin : g_src
      localparam logic [11:0] CTL_OFS = (s == 0) ? FIFO_CTRL_OFS : QUEUE_CTRL_OFS;
      logic ctlWr;
      logic incReq;
      logic take;
      logic [6:0] slotBytes;

      // a function result cannot be part-selected, so land it in a net first
      assign slotBytes = plsizeBytes(payload_size_field_reg[s]);
      assign objWords[s] = 5'(HDR_WORDS) + slotBytes[6:2];
      assign count[s] = head_reg[s] - tail_reg[s];
      assign full[s] = (count[s] == 3'(OBJ_DEPTH));
      assign empty[s] = (head_reg[s] == tail_reg[s]);
      assign headWord[s] = {1'b0, regionBase[s]}
        + 8'(head_reg[s][1:0] * objWords[s]);
      assign tailWord[s] = {1'b0, regionBase[s]}
        + 8'(tail_reg[s][1:0] * objWords[s]);
      // user address is relative to the ram base
      assign userAddr[s] = {2'b00, headWord[s], 2'b00};
      assign statusWord[s] = {21'h0, count[s], 5'h0, refused_reg[s],
        empty[s], ~full[s]};
      assign ctlWr = regWrEn && (regAddr == CTL_OFS);
      assign incReq = ctlWr && regWrData[INC_BIT];
      assign take = engTake && (engSel == 1'(s)) && !empty[s];

      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          payload_size_field_reg[s] <= PAYLOAD_SIZE_FIELD_RESET;
        end
        else if (ctlWr)
        begin
          // resizing with objects held misplaces them; host empties first
          payload_size_field_reg[s] <= regWrData[2:0];
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          head_reg[s] <= 3'h0;
        end
        else if (incReq && !full[s])
        begin
          head_reg[s] <= head_reg[s] + 3'h1;
        end
      end

      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          tail_reg[s] <= 3'h0;
        end
        else if (take)
        begin
          tail_reg[s] <= tail_reg[s] + 3'h1;
        end
      end

      // increment into a full source is dropped and remembered;
      // write 1 at bit REFUSED_BIT of the status word clears it, set wins
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          refused_reg[s] <= 1'b0;
        end
        else if (incReq && full[s])
        begin
          refused_reg[s] <= 1'b1;
        end
        else if (regWrEn && regWrData[REFUSED_BIT]
          && regAddr == ((s == 0) ? FIFO_STAT_OFS : QUEUE_STAT_OFS))
        begin
          refused_reg[s] <= 1'b0;
        end
      end
    end
  endgenerate

  // queue region follows the whole fifo region
  assign regionBase[0] = 7'h00;
  assign regionBase[1] = 7'(OBJ_DEPTH * objWords[0]);

  // flags the host polls before loading
  assign fifoNotFull = ~full[0];
  assign queueNotFull = ~full[1];

  // ------------------------------------------------------------
  // engine side: oldest object of the selected source
  // ------------------------------------------------------------
  assign selTail = tailWord[engSel];
  assign engValid = ~empty[engSel];
  assign payloadIdx = selTail + 8'(HDR_WORDS) + {4'h0, engWordIdx};

  assign obj.t0 = msgRam[selTail];
  assign obj.t1 = msgRam[selTail + 8'h01];
  assign obj.gatewayMode = ctrl_reg[GATEWAY_BIT];
  assign obj.classicOnly = ctrl_reg[CLASSIC_BIT];
  assign obj.reducedSeq = ctrl_reg[REDUCED_SEQ_BIT];
  assign obj.errPassive = errPassive;
  assign obj.capBytes = plsizeBytes(payload_size_field_reg[engSel]);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      engWord <= 32'h0;
    end
    else
    begin
      engWord <= msgRam[payloadIdx];
    end
  end

  // decoded header, one cycle behind the selection
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      frameBaseId <= 12'h000;
      frameExtId <= 18'h00000;
      frameSeqTag <= 23'h000000;
      frameEsi <= 1'b0;
      frameFd <= 1'b0;
      frameBrs <= 1'b0;
      frameRtr <= 1'b0;
      frameIde <= 1'b0;
      frameDlc <= 4'h0;
      frameByteCount <= 7'h00;
    end
    else
    begin
      frameBaseId <= obj.baseId;
      frameExtId <= obj.extId;
      frameSeqTag <= obj.seqTag;
      frameEsi <= obj.esi;
      frameFd <= obj.fdFrame;
      frameBrs <= obj.brs;
      frameRtr <= obj.rtr;
      frameIde <= obj.ide;
      frameDlc <= obj.dlc;
      frameByteCount <= obj.byteCount;
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  always_comb
  begin
    rdValue = 32'h0;
    if (ramHit)
    begin
      rdValue = msgRam[ramIdx];
    end
    else
    begin
      case (regAddr)
        CTRL_OFS: rdValue = {29'h0, ctrl_reg};
        FIFO_CTRL_OFS: rdValue = {29'h0, payload_size_field_reg[0]};
        FIFO_STAT_OFS: rdValue = statusWord[0];
        FIFO_UA_OFS: rdValue = {20'h0, userAddr[0]};
        QUEUE_CTRL_OFS: rdValue = {29'h0, payload_size_field_reg[1]};
        QUEUE_STAT_OFS: rdValue = statusWord[1];
        QUEUE_UA_OFS: rdValue = {20'h0, userAddr[1]};
        default: rdValue = 32'h0;
      endcase
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      regRdData <= 32'h0;
    end
    else
    begin
      regRdData <= regRdEn ? rdValue : 32'h0;
    end
  end
endmodule // can_tx_loader

// file: bench/can_tx_loader_props.sv
// Purpose: port-level properties of the transmit object loader
// Assumes: bound to can_tx_loader, one clock
// Notes: frame relations judged once the object has settled, except ESI against error passive
`timescale 1ns/100ps
module can_tx_loader_props
  import can_tx_loader_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic errPassive,
  input wire logic engSel,
  input wire logic engTake,
  input wire logic engValid,
  input wire logic [11:0] frameBaseId,
  input wire logic frameEsi,
  input wire logic frameFd,
  input wire logic frameBrs,
  input wire logic frameRtr,
  input wire logic [3:0] frameDlc,
  input wire logic [6:0] frameByteCount,
  input wire logic fifoNotFull
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic fifoInc = regWrEn && regAddr == FIFO_CTRL_OFS && regWrData[INC_BIT];
  wire logic queueInc = regWrEn && regAddr == QUEUE_CTRL_OFS && regWrData[INC_BIT];
  // --------------------------------
  // properties
  // --------------------------------
  // frame outputs lag one cycle, so skip the cycle after a take or switch
  sequence settled;
    engValid && $past(engValid) && $stable(engSel) && !$past(engTake);
  endsequence
  a_rtr_classic_only: assert property (settled ##0 frameFd |-> !frameRtr)
    else $error("remote request in fd frame");
  a_brs_fd_only: assert property (settled ##0 frameBrs |-> frameFd)
    else $error("rate switch without fd");
  a_sid_twelve_fd: assert property (settled ##0 !frameFd |-> !frameBaseId[11])
    else $error("twelfth id bit in classic frame");
  a_classic_len: assert property (settled ##0 !frameFd |->
    frameByteCount == ((frameDlc > 4'h8) ? 7'h08 : {3'h0, frameDlc}))
    else $error("classic byte count wrong");
  a_esi_passive: assert property (!$past(rst) && $past(errPassive) |-> frameEsi)
    else $error("esi low while error passive");
  a_fifo_inc_fills: assert property (fifoInc && fifoNotFull && !engSel |=> engSel || engValid)
    else $error("fifo increment lost");
  a_queue_inc_fills: assert property (queueInc && engSel |=> !engSel || engValid)
    else $error("queue increment lost");
  a_full_refused: assert property (fifoInc && !fifoNotFull && !(engTake && !engSel)
    |=> !fifoNotFull)
    else $error("increment accepted while full");
  a_rd_idle_zero: assert property (!$past(regRdEn) |-> regRdData == 32'h0)
    else $error("read data outside read answer");
  c_full_inc: cover property (fifoInc && !fifoNotFull);
  c_take: cover property (engTake && engValid);
  c_fd_brs: cover property (settled ##0 frameFd && frameBrs);
endmodule // can_tx_loader_props

bind can_tx_loader can_tx_loader_props props (.clk_sys, .rst, .regAddr, .regWrData,
  .regWrEn, .regRdEn, .regRdData, .errPassive, .engSel, .engTake, .engValid, .frameBaseId,
  .frameEsi, .frameFd, .frameBrs, .frameRtr, .frameDlc, .frameByteCount, .fifoNotFull);

// file: bench/can_host_model.sv
// Purpose: host side of the register port, loads transmit objects
// Assumes: reads answer one cycle after the strobe
// Notes: refuses to load when status shows no room
`timescale 1ns/100ps
module can_host_model
(
  input wire logic clk_sys,
  output logic [11:0] regAddr,
  output logic [31:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire logic [31:0] regRdData
);
  import can_tx_loader_pkg::*;
  initial
  begin
    regAddr = 12'h000;
    regWrData = 32'h0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  // released data shows the inverse, so a stale value cannot pass
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic load(input logic q, input logic [31:0] w [4], output logic ok);
    logic [31:0] st;
    logic [31:0] ua;
    rd(q ? QUEUE_STAT_OFS : FIFO_STAT_OFS, st);
    ok = st[NOT_FULL_BIT];
    if (ok)
    begin
      rd(q ? QUEUE_UA_OFS : FIFO_UA_OFS, ua);
      for (int i = 0; i < 4; i++)
        wr(RAM_BASE + ua[11:0] + 12'(4 * i), w[i]);
      wr(q ? QUEUE_CTRL_OFS : FIFO_CTRL_OFS, 32'h1 << INC_BIT);
    end
  endtask
endmodule // can_host_model

// file: bench/test_can_tx_loader.sv
// Purpose: self-checking bench for the transmit object loader
// Assumes: payload code left at 8 bytes
// Notes: register reads checked from a queue of notes
`timescale 1ns/100ps
module test_can_tx_loader;
  import can_tx_loader_pkg::*;
  typedef struct {string nm; logic [31:0] v;} note_t;
  logic clk_sys, rst, regWrEn, regRdEn, errPassive, engSel, engTake, engValid, rdSeen, ok;
  logic [11:0] regAddr, frameBaseId;
  logic [31:0] regWrData, regRdData, engWord;
  logic [3:0] engWordIdx, frameDlc;
  logic [17:0] frameExtId;
  logic [22:0] frameSeqTag;
  logic frameEsi, frameFd, frameBrs, frameRtr, frameIde, fifoNotFull, queueNotFull;
  logic [6:0] frameByteCount;
  logic [31:0] obj [5][4];
  logic [2:0] c;
  note_t expQ[$];
  note_t n;
  int errors, total_checks, r;
  wire logic [68:0] frame = {frameBaseId, frameExtId, frameSeqTag, frameEsi, frameFd,
    frameBrs, frameRtr, frameIde, frameDlc, frameByteCount};
  can_tx_loader DUT (.clk_sys, .rst, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
    .errPassive, .engSel, .engTake, .engWordIdx, .engValid, .engWord, .frameBaseId,
    .frameExtId, .frameSeqTag, .frameEsi, .frameFd, .frameBrs, .frameRtr, .frameIde,
    .frameDlc, .frameByteCount, .fifoNotFull, .queueNotFull);
  can_host_model host (.clk_sys, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData);
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic cmp(input string nm, input logic [68:0] e, input logic [68:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    expQ.push_back('{nm, e});
    host.rd(a, d);
  endtask
  always @(posedge clk_sys)
  begin
    rdSeen <= regRdEn;
    if (rdSeen && expQ.size() > 0)
    begin
      n = expQ.pop_front();
      cmp(n.nm, 69'(n.v), 69'(regRdData));
    end
  end
  function automatic logic [68:0] expFrame(input logic [31:0] t0, t1, input logic [2:0] m,
    input logic ep);
    logic fd;
    logic [3:0] dlc;
    fd = t1[T1_FDF_BIT] & ~m[CLASSIC_BIT];
    dlc = t1[3:0];
    return {fd & t0[T0_BASE_IDENTIFIER_BIT_ELEVEN_BIT], t0[10:0], t0[28:11],
      m[REDUCED_SEQ_BIT] ? {16'h0, t1[15:9]} : t1[31:9],
      m[GATEWAY_BIT] ? (t1[8] | ep) : ep, fd, t1[6] & fd, t1[5] & ~fd, t1[4], dlc,
      (dlc > 4'h8) ? 7'h08 : {3'h0, dlc}};
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    results();
  end
  initial
  begin
    {rst, errPassive, engSel, engTake, engWordIdx} = 8'h80;
    errors = 0;
    total_checks = 0;
    r = $urandom(32'h0e6b);
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdChk("fifo status", FIFO_STAT_OFS, 32'h3);
    rdChk("queue ua", QUEUE_UA_OFS, 32'h40);
    rdChk("unmapped", 12'h020, 32'h0);
    $display("test reset done");
    for (int k = 0; k < 5; k++)
    begin
      for (int i = 0; i < 4; i++)
        obj[k][i] = $urandom;
      host.load(1'b0, obj[k], ok);
      cmp("accepted", 69'(k < 4), 69'(ok));
      if (ok)
        rdChk("fifo ua", FIFO_UA_OFS, 32'(16 * ((k + 1) % 4)));
    end
    host.wr(FIFO_CTRL_OFS, 32'h1 << INC_BIT);
    rdChk("full status", FIFO_STAT_OFS, 32'h404);
    cmp("not full", 69'h0, 69'(fifoNotFull));
    $display("test fill done");
    for (int k = 0; k < 4; k++)
    begin
      c = 3'(3 * k + 1);
      host.wr(CTRL_OFS, 32'(c));
      errPassive <= 1'($urandom);
      engWordIdx <= 4'h0;
      repeat (3) @(posedge clk_sys);
      #1 cmp("frame", expFrame(obj[k][0], obj[k][1], c, errPassive), frame);
      cmp("word t2", 69'(obj[k][2]), 69'(engWord));
      @(posedge clk_sys);
      engWordIdx <= 4'h1;
      @(posedge clk_sys);
      #1 cmp("word t3", 69'(obj[k][3]), 69'(engWord));
      @(posedge clk_sys);
      engTake <= 1'b1;
      @(posedge clk_sys);
      engTake <= 1'b0;
    end
    #1 cmp("drained", 69'h0, 69'(engValid));
    rdChk("refused kept", FIFO_STAT_OFS, 32'h7);
    host.wr(FIFO_STAT_OFS, 32'h1 << REFUSED_BIT);
    rdChk("refused cleared", FIFO_STAT_OFS, 32'h3);
    host.wr(FIFO_CTRL_OFS, 32'h5);
    rdChk("payload code", FIFO_CTRL_OFS, 32'h5);
    host.wr(FIFO_CTRL_OFS, 32'h0);
    $display("test drain done");
    engSel <= 1'b1;
    host.load(1'b1, obj[4], ok);
    rdChk("queue ua", QUEUE_UA_OFS, 32'h50);
    repeat (2) @(posedge clk_sys);
    #1 cmp("queue frame", expFrame(obj[4][0], obj[4][1], c, errPassive), frame);
    cmp("queue accepted", 69'h1, 69'(ok));
    cmp("queue not full", 69'h1, 69'(queueNotFull));
    $display("test queue done");
    results();
  end
endmodule // test_can_tx_loader
